/* temp_alert_output_logic.sv */
// Drives the open-drain over-temperature alert pin from limit comparisons.
// Assumes config bits are written by the serial front end and stay static
// between conversions; register_read pulses once per host register read.
`timescale 1ns/1ps
module temp_alert_output_logic
   import alert_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rstn,
   input  wire logic [TEMP_W-1:0]  temp_result,
   input  wire logic               result_valid,
   input  wire logic               limit_wr,
   input  wire logic [TEMP_W-1:0]  limit_wdata,
   input  wire logic               hyst_wr,
   input  wire logic [TEMP_W-1:0]  hyst_wdata,
   input  wire logic               cfg_wr,
   input  wire logic               cfg_interrupt_mode,
   input  wire logic               cfg_smbus_alert,
   input  wire logic               cfg_active_high,
   input  wire logic [FAULT_W-1:0] cfg_fault_count,
   input  wire logic               shutdown,
   input  wire logic               register_read,
   output logic [TEMP_W-1:0]       over_temp_limit,
   output logic [TEMP_W-1:0]       hysteresis_limit,
   output logic                    interrupt_mode,
   output logic                    smbus_alert_mode,
   output logic                    active_high,
   output logic [FAULT_W-1:0]      fault_count,
   output logic                    alert_active,
   output logic                    over_temp_alert_output_o,
   output logic                    over_temp_alert_output_oe_n
);
   alert_cmp_if cmp ();

   int_state_e           state;
   int_state_e           next_state;
   logic                 cmp_alert;
   logic [FAULT_W-1:0]   faults;
   logic [FAULT_W-1:0]   next_faults;
   logic                 next_cmp_alert;

   wire logic            alert_level;
   wire logic            int_alert;
   wire logic            fault_hit;
   wire logic [FAULT_W-1:0] fault_need;
   wire logic            sample_hit;
   wire logic            sample_miss;
   wire logic [FAULT_W-1:0] fault_incr;
   wire logic            next_oe_n;

   temp_compare u_compare (
      .clk              (clk),
      .rstn             (rstn),
      .temp_result      (temp_result),
      .result_valid     (result_valid),
      .over_temp_limit  (over_temp_limit),
      .hysteresis_limit (hysteresis_limit),
      .cmp              (cmp)
   );

   // Limits; shutdown has no say here, the host may rewrite them any time
   always_ff @(posedge clk) begin
      if (!rstn) begin
         over_temp_limit <= LIMIT_RESET;
      end else if (limit_wr) begin
         over_temp_limit <= limit_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         hysteresis_limit <= HYST_RESET;
      end else if (hyst_wr) begin
         hysteresis_limit <= hyst_wdata;
      end
   end

   // Configuration fields load together on one strobe
   always_ff @(posedge clk) begin
      if (!rstn) begin
         interrupt_mode <= OP_MODE_RESET;
      end else if (cfg_wr) begin
         interrupt_mode <= cfg_interrupt_mode;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         smbus_alert_mode <= ALERT_SEL_RESET;
      end else if (cfg_wr) begin
         smbus_alert_mode <= cfg_smbus_alert;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         active_high <= POLARITY_RESET;
      end else if (cfg_wr) begin
         active_high <= cfg_active_high;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         fault_count <= FAULT_RESET;
      end else if (cfg_wr) begin
         fault_count <= cfg_fault_count;
      end
   end

   assign sample_hit  = cmp.sample && cmp.at_or_above_limit;
   assign sample_miss = cmp.sample && !cmp.at_or_above_limit;
   assign fault_incr  = faults + FAULT_W'(1);

   // Zero count treated as one so the alert can still fire
   assign fault_need = (fault_count == '0) ? FAULT_W'(1) : fault_count;
   assign fault_hit  = sample_hit && (fault_incr >= fault_need);

   // Comparator path; shutdown neither stops new samples nor clears
   always_comb begin
      next_cmp_alert = cmp_alert;
      if (cmp.sample) begin
         if (cmp.at_or_above_limit) begin
            next_cmp_alert = 1'b1;
         end else if (cmp.below_hyst) begin
            next_cmp_alert = 1'b0;
         end
      end
   end

   // Interrupt path state machine
   always_comb begin
      next_state  = state;
      next_faults = faults;
      case (state)
         ST_IDLE: begin
            if (sample_miss) begin
               next_faults = '0;
            end else if (fault_hit) begin
               next_faults = '0;
               next_state  = ST_LATCHED;
            end else if (sample_hit) begin
               next_faults = fault_incr;
            end
         end
         ST_LATCHED: begin
            if (register_read) begin
               next_state = ST_ARMED;
            end
         end
         ST_ARMED: begin
            // A new event needs a fresh excursion below the limit first
            if (sample_miss) begin
               next_state  = ST_IDLE;
               next_faults = '0;
            end
         end
         default: begin
            next_state  = ST_IDLE;
            next_faults = '0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state     <= ST_IDLE;
         faults    <= '0;
         cmp_alert <= 1'b0;
      end else if (!interrupt_mode) begin
         state     <= ST_IDLE;
         faults    <= '0;
         cmp_alert <= next_cmp_alert;
      end else begin
         state     <= next_state;
         faults    <= next_faults;
         cmp_alert <= 1'b0;
      end
   end

   assign int_alert   = (state == ST_LATCHED);
   assign alert_level = interrupt_mode ? int_alert : cmp_alert;

   // Open drain pulls low when active-low and asserted
   assign next_oe_n = ~(alert_level ^ active_high);

   // Status copy of the alert, independent of polarity
   always_ff @(posedge clk) begin
      if (!rstn) begin
         alert_active <= 1'b0;
      end else begin
         alert_active <= alert_level;
      end
   end

   // Pin data stays low; only the enable moves, so the pin never drives high
   always_ff @(posedge clk) begin
      if (!rstn) begin
         over_temp_alert_output_o <= 1'b0;
      end else begin
         over_temp_alert_output_o <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         over_temp_alert_output_oe_n <= 1'b1;
      end else begin
         over_temp_alert_output_oe_n <= next_oe_n;
      end
   end
endmodule : temp_alert_output_logic

/* alert_pkg.sv */
// Constants for the over-temperature alert output logic.
// Assumes 12-bit signed temperature results in a 16-bit left-justified word.
package alert_pkg;
   localparam int          TEMP_W          = 16;
   localparam int          FAULT_W         = 3;
   // +80 degC, left-justified, 1/16 degC per LSB in bits 15:4
   localparam logic [15:0] LIMIT_RESET     = 16'h5000;
   // +75 degC default hysteresis
   localparam logic [15:0] HYST_RESET      = 16'h4B00;
   localparam logic [2:0]  FAULT_RESET     = 3'h1;
   localparam logic        POLARITY_RESET  = 1'b0;
   localparam logic        OP_MODE_RESET   = 1'b0;
   localparam logic        ALERT_SEL_RESET = 1'b0;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_ARMED   = 2'b01,
      ST_LATCHED = 2'b10
   } int_state_e;
endpackage : alert_pkg

/* alert_cmp_if.sv */
// Comparison results passed from the comparator to the alert controller.
// Assumes a single clock domain.
`timescale 1ns/1ps
interface alert_cmp_if;
   logic at_or_above_limit;
   logic below_hyst;
   logic sample;

   modport producer (output at_or_above_limit, output below_hyst, output sample);
   modport consumer (input at_or_above_limit, input below_hyst, input sample);
endinterface : alert_cmp_if

/* temp_compare.sv */
// Signed compare of each new temperature result against both limits.
// Assumes result_valid pulses one cycle per finished conversion.
`timescale 1ns/1ps
module temp_compare
   import alert_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic [TEMP_W-1:0] temp_result,
   input  wire logic              result_valid,
   input  wire logic [TEMP_W-1:0] over_temp_limit,
   input  wire logic [TEMP_W-1:0] hysteresis_limit,
   alert_cmp_if.producer          cmp
);
   wire logic ge_limit;
   wire logic lt_hyst;

   assign ge_limit = $signed(temp_result) >= $signed(over_temp_limit);
   assign lt_hyst  = $signed(temp_result) < $signed(hysteresis_limit);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         cmp.at_or_above_limit <= 1'b0;
         cmp.below_hyst        <= 1'b0;
         cmp.sample            <= 1'b0;
      end else begin
         cmp.sample <= result_valid;
         if (result_valid) begin
            cmp.at_or_above_limit <= ge_limit;
            cmp.below_hyst        <= lt_hyst;
         end
      end
   end
endmodule : temp_compare

/* temp_alert_props.sv */
// Port checks for the alert output block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module temp_alert_props (
   input wire logic clk,
   input wire logic rstn,
   input wire logic result_valid,
   input wire logic cfg_wr,
   input wire logic register_read,
   input wire logic interrupt_mode,
   input wire logic active_high,
   input wire logic alert_active,
   input wire logic over_temp_alert_output_o,
   input wire logic over_temp_alert_output_oe_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   logic [2:0] rv_h, ev_h;
   wire        calm = !result_valid && !cfg_wr && ev_h == 3'h0;
   always_ff @(posedge clk) begin
      rv_h <= rstn ? {rv_h[1:0], result_valid} : 3'h0;
      ev_h <= rstn ? {ev_h[1:0], result_valid | register_read | cfg_wr} : 3'h0;
   end
   sequence int_ack; interrupt_mode && alert_active && register_read; endsequence
   reset_state_a: assert property ($rose(rstn) |-> !interrupt_mode && !alert_active)
      else $error("bad reset state");
   drive_low_a: assert property (!over_temp_alert_output_o)
      else $error("pin data high");
   pin_level_a: assert property ($stable(alert_active) && $stable(active_high) |->
      over_temp_alert_output_oe_n == (alert_active ~^ active_high)) else $error("bad pin");
   read_clear_a: assert property (int_ack |-> ##[1:2] !alert_active)
      else $error("read kept alert");
   latch_hold_a: assert property (interrupt_mode && alert_active && !register_read && calm
      |=> alert_active) else $error("latched alert lost");
   cmp_read_a: assert property (!interrupt_mode && alert_active && register_read && calm
      |=> alert_active) else $error("read cleared alert");
   rise_cause_a: assert property ($rose(alert_active) |-> rv_h != 3'h0)
      else $error("alert without sample");
   fall_cause_a: assert property ($fell(alert_active) |-> ev_h != 3'h0)
      else $error("alert fell alone");
endmodule : temp_alert_props

/* alert_host_model.sv */
// Host model: polls the pulled-up alert wire and acknowledges by reading.
// Assumes active_high mirrors the block's stored polarity.
`timescale 1ns/1ps
module alert_host_model (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       alert_wire,
   input  wire logic       active_high,
   input  wire logic [1:0] wait_cycles,
   output logic            register_read
);
   int cnt = 0;
   initial register_read = 1'b0;
   // Keeps polling while the wire stays active, as a real host would
   always @(negedge clk) begin
      register_read <= 1'b0;
      if (!rstn || alert_wire !== active_high || cnt == 10) cnt = 0;
      else if (cnt++ == wait_cycles) register_read <= 1'b1;
   end
endmodule : alert_host_model

/* temp_alert_output_logic_test.sv */
// Bench: reference model against the alert block, host model answering.
// Assumes host reads land before the next conversion result.
`timescale 1ns/1ps
module temp_alert_output_logic_test
   import alert_pkg::*;
;
   logic        clk = 0, rstn = 0, rv = 0, lw = 0, hw = 0, cw = 0, rd;
   logic        im = 0, sa = 0, ah = 0, sd = 0, ia, ahq, act, po, poe, saq;
   logic [2:0]  fc = 3'h1, fcq;
   logic [1:0]  hd = 2'h3;
   logic [15:0] tr = 16'h0, wd = 16'h0, lim, hys;
   int          n_mismatch = 0, total_checks = 0, seed = 35702;
   int          e_lim, e_hys, e_im, e_ah, e_fc, run, ex, low;
   logic [15:0] plan [12] = '{16'h5000, 16'h5000, 16'h4000, 16'h5010, 16'h7FF0,
      16'h5000, 16'h5000, 16'h4FF0, 16'h5000, 16'h5000, 16'h5000, 16'h4000};
   temp_alert_output_logic u_temp_alert_output_logic (.clk(clk), .rstn(rstn),
      .temp_result(tr), .result_valid(rv), .limit_wr(lw), .limit_wdata(wd), .hyst_wr(hw),
      .hyst_wdata(wd), .cfg_wr(cw), .cfg_interrupt_mode(im), .cfg_smbus_alert(sa),
      .cfg_active_high(ah), .cfg_fault_count(fc), .shutdown(sd), .register_read(rd),
      .over_temp_limit(lim), .hysteresis_limit(hys), .interrupt_mode(ia), .fault_count(fcq),
      .smbus_alert_mode(saq), .active_high(ahq), .alert_active(act),
      .over_temp_alert_output_o(po), .over_temp_alert_output_oe_n(poe));
   // Pull-up on the open-drain wire
   alert_host_model u_alert_host_model (.clk(clk), .rstn(rstn), .alert_wire(poe ? 1'b1 : po),
      .active_high(ahq), .wait_cycles(hd), .register_read(rd));
   always @(posedge clk) begin
      if (!rstn || (cw && im != e_im)) {ex, run, low} = 96'd0;
      if (!rstn) {e_lim, e_hys, e_im, e_ah, e_fc} = {32'($signed(LIMIT_RESET)), 32'sd19200, 96'd1};
      if (rstn && cw) {e_im, e_ah, e_fc} = {32'(im), 32'(ah), fc == 3'h0 ? 32'd1 : 32'(fc)};
      if (rstn && lw) e_lim = $signed(wd);
      if (rstn && hw) e_hys = $signed(wd);
      if (rstn && rv && !e_im) begin
         if ($signed(tr) >= e_lim) ex = 1;
         else if ($signed(tr) < e_hys) ex = 0;
      end else if (rstn && rv && $signed(tr) < e_lim) {run, low} = 64'd0;
      else if (rstn && rv && !low && ++run >= e_fc) ex = 1;
      if (rstn && rd && e_im && ex) {ex, low, run} = {32'd0, 32'd1, 32'd0};
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      total_checks++;
      if (seen !== want) begin
         n_mismatch++;
         $display("ERROR %0t: got %h, expected %h", $time, seen, want);
      end
   endtask : check
   task automatic sample(input logic [15:0] t);
      @(negedge clk) {tr, rv} = {t, 1'b1};
      @(negedge clk) rv = 0;
      repeat (5) @(negedge clk);
      if (hd == 2'h3) check(act, 16'(ex));
      repeat (8) @(negedge clk);
      check(act, 16'(ex));
      check(poe, 16'(ex == e_ah));
   endtask : sample
   task automatic setup(input logic m, s, h, input logic [2:0] f);
      @(negedge clk) {im, sa, ah, fc, cw} = {m, s, h, f, 1'b1};
      @(negedge clk) cw = 0;
      check({ia, saq, ahq, fcq}, {m, s, h, f});
   endtask : setup
   task automatic wlim(input logic l, input logic [15:0] v);
      @(negedge clk) {wd, lw, hw} = {v, l, !l};
      @(negedge clk) {lw, hw} = 2'b00;
      if (l) check(lim, v);
      else check(hys, v);
   endtask : wlim
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : complete_run
   initial forever #10 clk = ~clk;
   initial begin
      #400000 n_mismatch++;
      complete_run();
   end
   initial begin
      repeat (3) @(negedge clk);
      rstn = 1;
      check(lim, LIMIT_RESET);
      check({ia, act, poe}, 16'h1);
      sample(16'h5000);
      sd = 1;
      sample(16'h4B00);
      sd = 0;
      sample(16'h4AF0);
      setup(1, 0, 0, 3'h3);
      foreach (plan[i]) sample(plan[i]);
      setup(1, 1, 1, 3'h0);
      sample(16'h5000);
      wlim(1, 16'hFF00);
      wlim(0, 16'hFE00);
      setup(0, 0, 0, 3'h1);
      sample(16'h0010);
      sample(16'h8000);
      repeat (60) begin
         if ($random(seed) % 5 == 0) begin
            hd = 2'($random(seed));
            wlim(1, 16'($random(seed) % 16384));
            wlim(0, 16'(e_lim - 256));
            setup(1'($random(seed)), 1'($random(seed)), 1'($random(seed)), 3'($random(seed)));
         end
         sample(16'(e_lim + $random(seed) % 512));
      end
      @(negedge clk) rstn = 0;
      repeat (3) @(negedge clk);
      rstn = 1;
      check(lim, LIMIT_RESET);
      check(act, 16'h0);
      complete_run();
   end
endmodule : temp_alert_output_logic_test
bind temp_alert_output_logic temp_alert_props u_temp_alert_props (.*);
